// >>> hdl/dcfr_top.sv
`timescale 1ns/10ps
// Function
// - Program writes to force reset ignored
// - Force reset register always reads zero
// - Debug write of bit 0 forces reset
// - Four comparator bytes clear on reset
// - Comparator bytes writable only while disarmed
// - Readout bytes read-only; high zero event-only
// - High read holds position; low advances
// - Event-only stores data bytes in low half
// - Low reads never advance while armed
// - Disarmed low read stores last opcode address
// - Eight deep; ninth read returns first
// - Enable bit refused while secure
// - Arm write sets flag; clears on completion
// - Bit 5 picks tag or force breaks
// - Break at trigger or buffer full
// - Event-only trigger codes break at buffer full, not trigger
// - Comparator A direction qualification bits
// - Comparator B direction qualification bits
// - Control register accessible at all times
// - Registers reachable by application programs
// - Codes 0011 and 0100 are event-only
module dcfr_top #(
    parameter int TRACE_DEPTH = dcfr_pkg::TRACE_DEPTH_DOC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_bdm,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic [15:0] i_cpu_addr,
    input  wire logic        i_cpu_rw,
    input  wire logic        i_cpu_valid,
    input  wire logic [7:0]  i_cpu_data,
    input  wire logic        i_opcode_fetch,
    input  wire logic        i_cof,
    input  wire logic        i_secure,
    input  wire logic [3:0]  i_trig_mode,
    input  wire logic        i_begin_trace,
    output logic             o_force_reset,
    output logic             o_break_req,
    output logic             o_break_tag,
    output logic             o_capture_active_flag,
    output logic             o_module_enable
);
    localparam int               CNT_W    = $clog2(TRACE_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TRACE_DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

    // A longer shift chain costs area for no debug gain
    if (TRACE_DEPTH < 2 || TRACE_DEPTH > 16) begin : g_bad_depth
        $error("TRACE_DEPTH must lie between 2 and 16");
    end

    function automatic logic hit(input logic [3:0] addr,
                                 input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction

    function automatic logic is_event_mode(input logic [3:0] mode);
        is_event_mode = (mode == dcfr_pkg::TRG_EVENT_B) ||
                        (mode == dcfr_pkg::TRG_A_THEN_EVT_B);
    endfunction

    function automatic logic is_a_then(input logic [3:0] mode);
        is_a_then = (mode == dcfr_pkg::TRG_A_THEN_B) ||
                    (mode == dcfr_pkg::TRG_A_THEN_EVT_B);
    endfunction

    // Reset release through two flops
    logic rst_sync1_reg;
    logic rst_sync2_reg;
    wire  rstn = rst_sync2_reg;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    logic [7:0]             comp_a_high_reg;
    logic [7:0]             comp_a_low_reg;
    logic [7:0]             comp_b_high_reg;
    logic [7:0]             comp_b_low_reg;
    logic [7:0]             control_reg;
    logic [7:0]             control_next;
    logic [15:0]            last_opcode_reg;
    logic [15:0]            trace_reg [TRACE_DEPTH];
    logic [CNT_W-1:0]       fill_cnt_reg;
    logic [CNT_W-1:0]       fill_cnt_next;
    logic                   force_reset_reg;
    logic                   break_req_reg;
    logic                   break_tag_reg;
    logic [7:0]             rdata_reg;
    dcfr_pkg::dcfr_state_t  state_reg;
    dcfr_pkg::dcfr_state_t  state_next;
    logic                   match_a;
    logic                   match_b;

    // Register port decode; program and debug host share it
    wire sel_ca_hi = hit(i_reg_addr, dcfr_pkg::OFS_COMP_A_HIGH);
    wire sel_ca_lo = hit(i_reg_addr, dcfr_pkg::OFS_COMP_A_LOW);
    wire sel_cb_hi = hit(i_reg_addr, dcfr_pkg::OFS_COMP_B_HIGH);
    wire sel_cb_lo = hit(i_reg_addr, dcfr_pkg::OFS_COMP_B_LOW);
    wire sel_tr_hi = hit(i_reg_addr, dcfr_pkg::OFS_TRACE_HIGH);
    wire sel_tr_lo = hit(i_reg_addr, dcfr_pkg::OFS_TRACE_LOW);
    wire sel_ctl   = hit(i_reg_addr, dcfr_pkg::OFS_CONTROL);
    wire sel_force = hit(i_reg_addr, dcfr_pkg::OFS_FORCE_RESET);

    wire armed      = control_reg[dcfr_pkg::BIT_CAPTURE_ARM];
    wire enabled    = control_reg[dcfr_pkg::BIT_MODULE_ENABLE];
    wire comp_wr_ok = !armed;

    wire wr_comp_any = i_reg_wr && (sel_ca_hi || sel_ca_lo ||
                                    sel_cb_hi || sel_cb_lo);
    wire wr_ca_hi    = i_reg_wr && sel_ca_hi && comp_wr_ok;
    wire wr_ca_lo    = i_reg_wr && sel_ca_lo && comp_wr_ok;
    wire wr_cb_hi    = i_reg_wr && sel_cb_hi && comp_wr_ok;
    wire wr_cb_lo    = i_reg_wr && sel_cb_lo && comp_wr_ok;
    wire wr_ctl      = i_reg_wr && sel_ctl;
    wire wr_force    = i_reg_wr && sel_force && i_reg_bdm;

    // Secure parts never get the module enabled
    wire en_grant  = i_reg_wdata[dcfr_pkg::BIT_MODULE_ENABLE] &&
                     !i_secure;
    wire arm_grant = i_reg_wdata[dcfr_pkg::BIT_CAPTURE_ARM] &&
                     en_grant;
    wire arm_start = wr_ctl && arm_grant;

    wire event_mode  = is_event_mode(i_trig_mode);
    wire a_then_mode = is_a_then(i_trig_mode);
    wire begin_mode  = i_begin_trace || event_mode;
    wire cpu_live    = i_cpu_valid && armed && enabled;
    wire cof_live    = i_cof && armed && enabled;

    wire [15:0] value_a = {comp_a_high_reg, comp_a_low_reg};
    wire [15:0] value_b = {comp_b_high_reg, comp_b_low_reg};

    dcfr_comparator i_dcfr_comparator_a (
        .i_value       (value_a),
        .i_cpu_addr    (i_cpu_addr),
        .i_cpu_rw      (i_cpu_rw),
        .i_cpu_valid   (cpu_live),
        .i_dir_qualify (control_reg[dcfr_pkg::BIT_DIR_QUALIFY_A]),
        .i_dir_value   (control_reg[dcfr_pkg::BIT_DIR_VALUE_A]),
        .o_match       (match_a)
    );

    dcfr_comparator i_dcfr_comparator_b (
        .i_value       (value_b),
        .i_cpu_addr    (i_cpu_addr),
        .i_cpu_rw      (i_cpu_rw),
        .i_cpu_valid   (cpu_live),
        .i_dir_qualify (control_reg[dcfr_pkg::BIT_DIR_QUALIFY_B]),
        .i_dir_value   (control_reg[dcfr_pkg::BIT_DIR_VALUE_B]),
        .o_match       (match_b)
    );

    // Range and data modes live outside this block and never trigger
    wire trig_hit =
        (i_trig_mode == dcfr_pkg::TRG_A_ONLY) ? match_a :
        (i_trig_mode == dcfr_pkg::TRG_A_OR_B) ? (match_a || match_b) :
        (i_trig_mode <= dcfr_pkg::TRG_A_THEN_EVT_B) ? match_b : 1'b0;

    wire in_seek = (state_reg == dcfr_pkg::ST_SEEK);
    wire in_fill = (state_reg == dcfr_pkg::ST_FILL);

    // End trace keeps the latest words, begin trace the first ones
    wire seek_store = in_seek && !begin_mode && cof_live;
    wire fill_evt   = event_mode ? match_b : cof_live;
    wire fill_store = (in_fill && fill_evt) ||
                      (in_seek && trig_hit && event_mode);
    wire end_done   = in_seek && trig_hit && !begin_mode;
    wire fill_done  = fill_store && (fill_cnt_reg == CNT_LAST);
    wire run_done   = end_done || fill_done;
    wire cap_store  = seek_store || fill_store;
    wire [15:0] cap_word = event_mode ? {8'h00, i_cpu_data} :
                                        i_cpu_addr;

    // A fetch in the read cycle counts as the most recent one
    wire        prof_fetch   = i_cpu_valid && i_opcode_fetch;
    wire [15:0] profile_word = prof_fetch ? i_cpu_addr : last_opcode_reg;
    wire        low_read     = i_reg_rd && sel_tr_lo;
    wire        prof_store   = low_read && !armed;
    wire        shift_en     = cap_store || prof_store;
    wire [15:0] shift_word   = cap_store ? cap_word : profile_word;

    // Timing hangs on run completion only; event trigger modes run to buffer full
    wire break_fire = control_reg[dcfr_pkg::BIT_BREAK_ENABLE] &&
                      run_done;

    // A new write wins over a run ending in the same cycle
    always_comb begin
        control_next = control_reg;
        if (run_done) begin
            control_next[dcfr_pkg::BIT_CAPTURE_ARM] = 1'b0;
        end
        if (wr_ctl) begin
            control_next = i_reg_wdata;
            control_next[dcfr_pkg::BIT_MODULE_ENABLE] = en_grant;
            control_next[dcfr_pkg::BIT_CAPTURE_ARM] = arm_grant;
        end
    end

    always_comb begin
        state_next    = state_reg;
        fill_cnt_next = fill_cnt_reg;
        case (state_reg)
            dcfr_pkg::ST_IDLE: begin
                state_next = dcfr_pkg::ST_IDLE;
            end
            dcfr_pkg::ST_WAIT_A: begin
                if (match_a) begin
                    state_next = dcfr_pkg::ST_SEEK;
                end
            end
            dcfr_pkg::ST_SEEK: begin
                if (trig_hit && begin_mode) begin
                    state_next = dcfr_pkg::ST_FILL;
                end else if (end_done) begin
                    state_next = dcfr_pkg::ST_IDLE;
                end
            end
            dcfr_pkg::ST_FILL: begin
                if (fill_done) begin
                    state_next = dcfr_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = dcfr_pkg::ST_IDLE;
            end
        endcase
        if (fill_store) begin
            fill_cnt_next = fill_cnt_reg + CNT_ONE;
        end
        if (fill_done || !armed) begin
            state_next = dcfr_pkg::ST_IDLE;
        end
        if (arm_start) begin
            state_next    = a_then_mode ? dcfr_pkg::ST_WAIT_A :
                                          dcfr_pkg::ST_SEEK;
            fill_cnt_next = CNT_ZERO;
        end
    end

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            comp_a_high_reg <= dcfr_pkg::COMP_RESET;
            comp_a_low_reg  <= dcfr_pkg::COMP_RESET;
            comp_b_high_reg <= dcfr_pkg::COMP_RESET;
            comp_b_low_reg  <= dcfr_pkg::COMP_RESET;
        end else begin
            if (wr_ca_hi) begin
                comp_a_high_reg <= i_reg_wdata;
            end
            if (wr_ca_lo) begin
                comp_a_low_reg <= i_reg_wdata;
            end
            if (wr_cb_hi) begin
                comp_b_high_reg <= i_reg_wdata;
            end
            if (wr_cb_lo) begin
                comp_b_low_reg <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            control_reg  <= dcfr_pkg::CTRL_RESET;
            state_reg    <= dcfr_pkg::ST_IDLE;
            fill_cnt_reg <= CNT_ZERO;
        end else begin
            control_reg  <= control_next;
            state_reg    <= state_next;
            fill_cnt_reg <= fill_cnt_next;
        end
    end

    // The request stays up until the system reset it causes
    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            force_reset_reg <= 1'b0;
        end else if (wr_force &&
                     i_reg_wdata[dcfr_pkg::BIT_FORCE_RESET]) begin
            force_reset_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            break_req_reg <= 1'b0;
            break_tag_reg <= 1'b0;
        end else begin
            break_req_reg <= break_fire;
            break_tag_reg <= break_fire &&
                             control_reg[dcfr_pkg::BIT_BREAK_TAG];
        end
    end

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            last_opcode_reg <= dcfr_pkg::WORD_RESET;
        end else if (prof_fetch) begin
            last_opcode_reg <= i_cpu_addr;
        end
    end

    // Shift chain: head is read out, new words enter at the tail
    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < TRACE_DEPTH; i++) begin
                trace_reg[i] <= dcfr_pkg::WORD_RESET;
            end
        end else if (shift_en) begin
            for (int i = 0; i < TRACE_DEPTH - 1; i++) begin
                trace_reg[i] <= trace_reg[i + 1];
            end
            trace_reg[TRACE_DEPTH - 1] <= shift_word;
        end
    end

    wire [7:0] head_high = event_mode ? dcfr_pkg::READ_ZERO :
                                        trace_reg[0][15:8];
    wire [7:0] head_low  = trace_reg[0][7:0];

    // Force reset and unused offsets read as zero
    wire [7:0] read_mux =
        sel_ca_hi ? comp_a_high_reg :
        sel_ca_lo ? comp_a_low_reg  :
        sel_cb_hi ? comp_b_high_reg :
        sel_cb_lo ? comp_b_low_reg  :
        sel_tr_hi ? head_high       :
        sel_tr_lo ? head_low        :
        sel_ctl   ? control_reg     :
        dcfr_pkg::READ_ZERO;

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= dcfr_pkg::READ_ZERO;
        end else if (i_reg_rd) begin
            rdata_reg <= read_mux;
        end
    end

    assign o_reg_rdata           = rdata_reg;
    assign o_force_reset         = force_reset_reg;
    assign o_break_req           = break_req_reg;
    assign o_break_tag           = break_tag_reg;
    assign o_capture_active_flag = armed;
    assign o_module_enable       = enabled;

    sequence s_prog_force_wr;
        i_reg_wr && sel_force && !i_reg_bdm;
    endsequence

    sequence s_debug_force_wr;
        i_reg_wr && sel_force && i_reg_bdm &&
        i_reg_wdata[dcfr_pkg::BIT_FORCE_RESET];
    endsequence

    sequence s_idle_low_read;
        low_read && !armed;
    endsequence

    property p_force_prog;
        @(posedge i_core_clk) disable iff (!rstn)
        s_prog_force_wr |=> $stable(force_reset_reg);
    endproperty

    property p_force_debug;
        @(posedge i_core_clk) disable iff (!rstn)
        s_debug_force_wr |=> force_reset_reg;
    endproperty

    property p_force_read;
        @(posedge i_core_clk) disable iff (!rstn)
        (i_reg_rd && sel_force) |=> (o_reg_rdata == dcfr_pkg::READ_ZERO);
    endproperty

    property p_comp_lock;
        @(posedge i_core_clk) disable iff (!rstn)
        (wr_comp_any && armed) |=> ($stable(value_a) && $stable(value_b));
    endproperty

    property p_event_high;
        @(posedge i_core_clk) disable iff (!rstn)
        (i_reg_rd && sel_tr_hi && event_mode) |=>
            (o_reg_rdata == dcfr_pkg::READ_ZERO);
    endproperty

    property p_armed_hold;
        @(posedge i_core_clk) disable iff (!rstn)
        (low_read && armed && !cap_store) |=> $stable(trace_reg[0]);
    endproperty

    property p_profile;
        @(posedge i_core_clk) disable iff (!rstn)
        s_idle_low_read |=>
            (trace_reg[TRACE_DEPTH - 1] == $past(profile_word));
    endproperty

    property p_secure;
        @(posedge i_core_clk) disable iff (!rstn)
        (wr_ctl && i_secure && !enabled) |=> !enabled;
    endproperty

    property p_break;
        @(posedge i_core_clk) disable iff (!rstn)
        break_fire |=> (o_break_req &&
            (o_break_tag == $past(control_reg[dcfr_pkg::BIT_BREAK_TAG])));
    endproperty

    force_prog_a: assert property (p_force_prog)
        else $error("program write changed force reset");
    force_debug_a: assert property (p_force_debug)
        else $error("debug write did not force reset");
    force_read_a: assert property (p_force_read)
        else $error("force reset read not zero");
    comp_lock_a: assert property (p_comp_lock)
        else $error("comparator written while armed");
    event_high_a: assert property (p_event_high)
        else $error("high readout not zero in event mode");
    armed_hold_a: assert property (p_armed_hold)
        else $error("low read advanced buffer while armed");
    profile_store_a: assert property (p_profile)
        else $error("profiling read stored wrong address");
    secure_enable_a: assert property (p_secure)
        else $error("module enabled while secure");
    break_type_a: assert property (p_break)
        else $error("break request or type wrong");
endmodule

// >>> hdl/dcfr_pkg.sv
package dcfr_pkg;

    // Byte register offsets on the register port
    localparam int         REG_ADDR_W       = 4;
    localparam logic [3:0] OFS_COMP_A_HIGH  = 4'h0;
    localparam logic [3:0] OFS_COMP_A_LOW   = 4'h1;
    localparam logic [3:0] OFS_COMP_B_HIGH  = 4'h2;
    localparam logic [3:0] OFS_COMP_B_LOW   = 4'h3;
    localparam logic [3:0] OFS_TRACE_HIGH   = 4'h4;
    localparam logic [3:0] OFS_TRACE_LOW    = 4'h5;
    localparam logic [3:0] OFS_CONTROL      = 4'h6;
    localparam logic [3:0] OFS_FORCE_RESET  = 4'h7;

    // Control and force reset register field positions
    localparam int BIT_MODULE_ENABLE  = 7;
    localparam int BIT_CAPTURE_ARM    = 6;
    localparam int BIT_BREAK_TAG      = 5;
    localparam int BIT_BREAK_ENABLE   = 4;
    localparam int BIT_DIR_VALUE_A    = 3;
    localparam int BIT_DIR_QUALIFY_A  = 2;
    localparam int BIT_DIR_VALUE_B    = 1;
    localparam int BIT_DIR_QUALIFY_B  = 0;
    localparam int BIT_FORCE_RESET    = 0;

    // Values after reset and fixed read values
    localparam logic [7:0] COMP_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] READ_ZERO    = 8'h00;
    localparam logic [15:0] WORD_RESET  = 16'h0000;

    // Trigger mode field codes
    localparam logic [3:0] TRG_A_ONLY       = 4'h0;
    localparam logic [3:0] TRG_A_OR_B       = 4'h1;
    localparam logic [3:0] TRG_A_THEN_B     = 4'h2;
    localparam logic [3:0] TRG_EVENT_B      = 4'h3;
    localparam logic [3:0] TRG_A_THEN_EVT_B = 4'h4;

    // Trace buffer shape
    localparam int TRACE_DEPTH_DOC = 8;
    localparam int TRACE_WORD_W    = 16;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_A,
        ST_SEEK,
        ST_FILL
    } dcfr_state_t;

endpackage

// >>> hdl/dcfr_comparator.sv
`timescale 1ns/10ps
module dcfr_comparator (
    input  wire logic [15:0] i_value,
    input  wire logic [15:0] i_cpu_addr,
    input  wire logic        i_cpu_rw,
    input  wire logic        i_cpu_valid,
    input  wire logic        i_dir_qualify,
    input  wire logic        i_dir_value,
    output logic             o_match
);
    // Direction is ignored unless qualification is on
    wire dir_ok = !i_dir_qualify || (i_cpu_rw == i_dir_value);
    assign o_match = i_cpu_valid && (i_cpu_addr == i_value) && dir_ok;
endmodule

// >>> bench/dcfr_cpu_model.sv
`timescale 1ns/10ps
module dcfr_cpu_model (
    input  wire logic        i_clk,
    output logic      [26:0] o_bus
);
    int seed = 86041;
    initial o_bus = '0;
    always @(posedge i_clk) o_bus <= #1 27'($random(seed));
endmodule

// >>> bench/tb_debug_compare_fifo_regs.sv
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb_debug_compare_fifo_regs;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, bdm = 0, sec = 0, fr, af, en;
    logic [3:0] ad = 0;
    logic [7:0] wd = 0, rdat, r, v;
    logic [26:0] cb;
    logic [3:0] tm = 0;
    logic [15:0] lf = 0;
    logic [15:0] q [8];
    logic bk, bt, brk_seen = 0;
    int num_errors = 0, comparisons = 0, seed = 86041;
    initial forever #12.5 clk = ~clk;
    dcfr_cpu_model i_dcfr_cpu_model (.i_clk(clk), .o_bus(cb));
    dcfr_top i_dcfr_top (.i_core_clk(clk), .i_rstn(rstn), .i_reg_addr(ad),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .i_reg_bdm(bdm),
        .o_reg_rdata(rdat), .i_cpu_addr(cb[15:0]), .i_cpu_rw(cb[16]),
        .i_cpu_valid(cb[17]), .i_cpu_data(cb[25:18]), .i_opcode_fetch(cb[26]),
        .i_cof(1'b0), .i_secure(sec), .i_trig_mode(tm), .i_begin_trace(1'b0),
        .o_force_reset(fr), .o_break_req(bk), .o_break_tag(bt),
        .o_capture_active_flag(af), .o_module_enable(en));
    always @(posedge clk) if (cb[17] && cb[26]) lf <= cb[15:0];
    always @(posedge clk) if (bk !== 1'b0 || bt !== 1'b0) brk_seen <= 1'b1;
    task wreg(input logic [3:0] a, input logic [7:0] d, input logic b = 0);
        @(posedge clk) #1 {ad, wd, bdm, wr} = {a, d, b, 1'b1};
        @(posedge clk) #1 {bdm, wr} = 2'b00;
    endtask
    task rreg(input logic [3:0] a);
        @(posedge clk) #1 {ad, rd} = {a, 1'b1};
        @(posedge clk) #1 begin
            r = rdat;
            rd = 0;
        end
    endtask
    function logic [7:0] ctl(input logic [7:0] d); return d & 8'h3F; endfunction
    task print_verdict;
        $display("%0d checks %0d errors", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin #100000 num_errors++; print_verdict; end
    initial begin
        repeat (3) @(posedge clk);
        #1 rstn = 1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 8; i++) if (i < 4 || i > 6) begin
            rreg(4'(i));
            `CHK(r, 8'h00)
        end
        wreg(dcfr_pkg::OFS_FORCE_RESET, 8'h01);
        `CHK(fr, 1'b0)
        for (int i = 0; i < 24; i++) begin
            v = (i < 2) ? {8{i[0]}} : 8'($random(seed));
            wreg(4'(i % 4), v);
            rreg(4'(i % 4));
            `CHK(r, v)
            wreg(dcfr_pkg::OFS_CONTROL, ctl(v));
            rreg(dcfr_pkg::OFS_CONTROL);
            `CHK(r, ctl(v))
        end
        wreg(dcfr_pkg::OFS_COMP_A_HIGH, 8'h5A);
        wreg(dcfr_pkg::OFS_CONTROL, 8'hC0);
        `CHK({en, af}, 2'b11)
        wreg(dcfr_pkg::OFS_COMP_A_HIGH, 8'hA5);
        rreg(dcfr_pkg::OFS_COMP_A_HIGH);
        `CHK(r, 8'h5A)
        wreg(dcfr_pkg::OFS_CONTROL, 8'h00);
        `CHK(af, 1'b0)
        $display("control and compare tests done");
        for (int k = 0; k < 16; k++) begin
            if (k >= 8) begin
                rreg(dcfr_pkg::OFS_TRACE_HIGH);
                `CHK(r, q[k % 8][15:8])
            end
            rreg(dcfr_pkg::OFS_TRACE_LOW);
            if (k >= 8) `CHK(r, q[k % 8][7:0])
            q[k % 8] = lf;
            if (k == 11) wreg(dcfr_pkg::OFS_TRACE_LOW, 8'hFF);
            if (k == 12) wreg(dcfr_pkg::OFS_TRACE_HIGH, 8'hFF);
        end
        rreg(dcfr_pkg::OFS_TRACE_HIGH);
        `CHK(r, q[0][15:8])
        tm = dcfr_pkg::TRG_EVENT_B;
        rreg(dcfr_pkg::OFS_TRACE_HIGH);
        `CHK(r, 8'h00)
        tm = dcfr_pkg::TRG_A_THEN_EVT_B;
        rreg(dcfr_pkg::OFS_TRACE_HIGH);
        `CHK(r, 8'h00)
        tm = dcfr_pkg::TRG_A_ONLY;
        `CHK(brk_seen, 1'b0)
        $display("trace readout tests done");
        sec = 1;
        wreg(dcfr_pkg::OFS_CONTROL, 8'h80);
        `CHK(en, 1'b0)
        wreg(dcfr_pkg::OFS_FORCE_RESET, 8'h01, 1'b1);
        `CHK(fr, 1'b1)
        $display("tests done");
        print_verdict;
    end
endmodule
